// ==== include/hrd_pkg.sv ====
// Shared constants and types for the host register space decoder
package hrd_pkg;

   // Host pin widths: 2 MB memory window, byte-wide data
   localparam int unsigned HOST_ADDR_W = 21;
   localparam int unsigned HOST_DATA_W = 8;
   localparam int unsigned REG_OFF_W   = 16;
   localparam int unsigned INT_DATA_W  = 16;
   localparam int unsigned MASK_W      = 5;

   // Register space ranges
   localparam logic [15:0] OFF_SYS_ASYNC_LO  = 16'h0020;
   localparam logic [15:0] OFF_SYS_ASYNC_HI  = 16'h004f;
   localparam logic [15:0] OFF_HOST_LO       = 16'h0080;
   localparam logic [15:0] OFF_HOST_SYNC_LO  = 16'h00a8;
   localparam logic [15:0] OFF_HOST_HI       = 16'h00af;
   localparam logic [15:0] OFF_INTERNAL_LO   = 16'h00b0;

   // Host-only register offsets
   localparam logic [15:0] OFF_UWA_LO   = 16'h0080;
   localparam logic [15:0] OFF_UWA_HI   = 16'h0081;
   localparam logic [15:0] OFF_UW_MASK  = 16'h0082;
   localparam logic [15:0] OFF_HCTL0    = 16'h0084;
   localparam logic [15:0] OFF_HCTL1    = 16'h0085;
   localparam logic [15:0] OFF_HCTL2    = 16'h008a;
   localparam logic [15:0] OFF_IND_CTL  = 16'h00a6;
   localparam logic [15:0] OFF_IND_A0   = 16'h00a8;
   localparam logic [15:0] OFF_IND_A1   = 16'h00a9;
   localparam logic [15:0] OFF_IND_A2   = 16'h00aa;
   localparam logic [15:0] OFF_IND_A3   = 16'h00ab;
   localparam logic [15:0] OFF_IND_D0   = 16'h00ac;
   localparam logic [15:0] OFF_IND_D1   = 16'h00ad;

   // Mirror of shared registers in the internal space
   localparam logic [31:0] INT_REG_BASE = 32'h3800_0000;

   // Values after reset
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [15:0] RST_HALF     = 16'h0000;
   localparam logic [31:0] RST_WORD     = 32'h0000_0000;
   localparam logic [4:0]  RST_MASK     = 5'h00;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BUSY = 3'b010,
      ST_HOLD = 3'b100
   } hrd_state_t;

endpackage

// ==== include/hrd_class_if.sv ====
// Offset classification signals between top and classifier
`timescale 1ns/1ps
interface hrd_class_if;
   logic [15:0] offset;
   logic        sync_type;
   logic        host_only;
   logic        shared;
   logic        local_hit;

   modport dec (input offset, output sync_type, host_only, shared,
                local_hit);
   modport use_side (output offset, input sync_type, host_only, shared,
                     local_hit);
endinterface

// ==== src/hrd_addr_class.sv ====
// Classifier of register space offsets by range and type
`timescale 1ns/1ps
module hrd_addr_class
(
   hrd_class_if.dec cls
);

   always_comb
   begin
      cls.host_only = (cls.offset >= hrd_pkg::OFF_HOST_LO) &&
                      (cls.offset <= hrd_pkg::OFF_HOST_HI);
      cls.shared    = !cls.host_only;
      if (cls.host_only)
      begin
         cls.sync_type = (cls.offset >= hrd_pkg::OFF_HOST_SYNC_LO);
      end
      else
      begin
         // Gap offset 001Fh is counted with the synchronous block
         cls.sync_type = !((cls.offset >= hrd_pkg::OFF_SYS_ASYNC_LO) &&
                           (cls.offset <= hrd_pkg::OFF_SYS_ASYNC_HI));
      end
      cls.local_hit = cls.offset inside {
         hrd_pkg::OFF_UWA_LO, hrd_pkg::OFF_UWA_HI, hrd_pkg::OFF_UW_MASK,
         hrd_pkg::OFF_HCTL0, hrd_pkg::OFF_HCTL1, hrd_pkg::OFF_HCTL2,
         hrd_pkg::OFF_IND_CTL, hrd_pkg::OFF_IND_A0, hrd_pkg::OFF_IND_A1,
         hrd_pkg::OFF_IND_A2, hrd_pkg::OFF_IND_A3, hrd_pkg::OFF_IND_D0,
         hrd_pkg::OFF_IND_D1};
   end

endmodule // hrd_addr_class

// ==== src/hrd_top.sv ====
// Host parallel port decoder with host-only registers and forwarding
`timescale 1ns/1ps
// Overview of operation
// RULE1: CS low: select low reaches registers, select high the memory window.
// RULE2: Register space is 64 KB, decoded from the sixteen low address lines.
// RULE3: System offsets sync except 0020-004F async; mirrored at 3800_xxxx.
// RULE4: Host-only registers: 0080-0084 asynchronous, 00A8-00AD synchronous.
// RULE5: Upper window address at 0080-0081, window mask bits 20:16 at 0082.
// RULE6: Indirect access: 32-bit address 00A8-00AB, 16-bit data 00AC-00AD.
// RULE7: Offsets 00B0-FFFF: synchronous, shared, mirrored internal registers.
// RULE8: In power-save mode the host touches asynchronous registers only; memory window accesses are still forwarded.
// RULE9: Converter ports unreachable from host; internal use 32-bit only.
// RULE10: With serial flash disabled, nobody accesses the flash read region.
// RULE11: Everything is one 32-bit memory-mapped internal address space.
// RULE12: Host activity with chip select high is ignored entirely.
module hrd_top
#(
   parameter logic [31:0] CONV_LO  = 32'hf000_0000,
   parameter logic [31:0] CONV_HI  = 32'hffff_ffff,
   parameter logic [31:0] FLASH_LO = 32'h2000_0000,
   parameter logic [31:0] FLASH_HI = 32'h2fff_ffff
)
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        host_cs_n,
   input  wire logic        host_mr_sel,
   input  wire logic        host_rd_n,
   input  wire logic        host_wr_n,
   input  wire logic [20:0] host_address_lines,
   input  wire logic [7:0]  host_data_in,
   output logic      [7:0]  host_data_out,
   output logic             host_data_oe,
   output logic             host_ready,
   input  wire logic        pwr_save_en,
   input  wire logic        spi_flash_en,
   output logic             int_req,
   output logic             int_we,
   output logic             int_size16,
   output logic      [31:0] int_addr,
   output logic      [15:0] int_wdata,
   input  wire logic        int_ack,
   input  wire logic [15:0] int_rdata,
   output logic             access_refused
);

   localparam int unsigned PIN_W =
      4 + hrd_pkg::HOST_ADDR_W + hrd_pkg::HOST_DATA_W;
   localparam logic [PIN_W-1:0] PIN_RST = {4'hb, {(PIN_W-4){1'b0}}};

   logic [PIN_W-1:0]   pin_s1_reg;
   logic [PIN_W-1:0]   pin_s2_reg;
   logic               cs_n_s;
   logic               mr_s;
   logic               rd_n_s;
   logic               wr_n_s;
   logic [20:0]        addr_s;
   logic [7:0]         data_s;
   logic               strobe_s;
   logic [31:0]        mem_addr;

   hrd_pkg::hrd_state_t state_reg;
   hrd_pkg::hrd_state_t state_next;
   logic [15:0]        uwa_reg;
   logic [15:0]        uwa_next;
   logic [4:0]         uwm_reg;
   logic [4:0]         uwm_next;
   logic [7:0]         hctl0_reg;
   logic [7:0]         hctl0_next;
   logic [7:0]         hctl1_reg;
   logic [7:0]         hctl1_next;
   logic [7:0]         hctl2_reg;
   logic [7:0]         hctl2_next;
   logic [7:0]         ictl_reg;
   logic [7:0]         ictl_next;
   logic [31:0]        iaddr_reg;
   logic [31:0]        iaddr_next;
   logic [7:0]         ilo_reg;
   logic [7:0]         ilo_next;
   logic [7:0]         ihi_reg;
   logic [7:0]         ihi_next;
   logic [7:0]         rdata_reg;
   logic [7:0]         rdata_next;
   logic               rd_reg;
   logic               rd_next;
   logic               mem_fwd_reg;
   logic               mem_fwd_next;
   logic               reg_fwd_reg;
   logic               reg_fwd_next;
   logic               ind_fwd_reg;
   logic               ind_fwd_next;
   logic               refused_reg;
   logic               refused_next;
   logic               req_reg;
   logic               req_next;
   logic               we_reg;
   logic               we_next;
   logic               sz16_reg;
   logic               sz16_next;
   logic [31:0]        iaout_reg;
   logic [31:0]        iaout_next;
   logic [15:0]        wd_reg;
   logic [15:0]        wd_next;

   hrd_class_if cls ();

   hrd_addr_class u_class
   (
      .cls (cls)
   );

   function automatic logic in_conv(input logic [31:0] a);
      return (a >= CONV_LO) && (a <= CONV_HI);
   endfunction

   function automatic logic blocked(input logic [31:0] a, input logic spi);
      return in_conv(a) || (!spi && (a >= FLASH_LO) && (a <= FLASH_HI));
   endfunction

   // Two-stage capture of every host pin
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         pin_s1_reg <= PIN_RST;
         pin_s2_reg <= PIN_RST;
      end
      else
      begin
         pin_s1_reg <= {host_cs_n, host_mr_sel, host_rd_n, host_wr_n,
                        host_address_lines, host_data_in};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   assign cs_n_s   = pin_s2_reg[PIN_W-1];
   assign mr_s     = pin_s2_reg[PIN_W-2];
   assign rd_n_s   = pin_s2_reg[PIN_W-3];
   assign wr_n_s   = pin_s2_reg[PIN_W-4];
   assign addr_s   = pin_s2_reg[PIN_W-5 -: hrd_pkg::HOST_ADDR_W];
   assign data_s   = pin_s2_reg[hrd_pkg::HOST_DATA_W-1:0];
   assign strobe_s = !rd_n_s || !wr_n_s;
   assign cls.offset = addr_s[15:0]; // RULE2

   // Window base with host lines substituted under the mask
   assign mem_addr = {uwa_reg[15:5],
                      (uwm_reg & addr_s[20:16]) |
                      (~uwm_reg & uwa_reg[4:0]),
                      addr_s[15:0]}; // RULE5

   always_comb
   begin
      logic        go;
      logic [31:0] go_addr;
      logic        go16;
      logic [15:0] go_wd;
      go           = 1'b0;
      go_addr      = hrd_pkg::RST_WORD;
      go16         = 1'b0;
      go_wd        = hrd_pkg::RST_HALF;
      state_next   = state_reg;
      uwa_next     = uwa_reg;
      uwm_next     = uwm_reg;
      hctl0_next   = hctl0_reg;
      hctl1_next   = hctl1_reg;
      hctl2_next   = hctl2_reg;
      ictl_next    = ictl_reg;
      iaddr_next   = iaddr_reg;
      ilo_next     = ilo_reg;
      ihi_next     = ihi_reg;
      rdata_next   = rdata_reg;
      rd_next      = rd_reg;
      mem_fwd_next = mem_fwd_reg;
      reg_fwd_next = reg_fwd_reg;
      ind_fwd_next = ind_fwd_reg;
      refused_next = 1'b0;
      req_next     = req_reg;
      we_next      = we_reg;
      sz16_next    = sz16_reg;
      iaout_next   = iaout_reg;
      wd_next      = wd_reg;
      unique case (state_reg)
         hrd_pkg::ST_IDLE:
         begin
            // Nothing is decoded while chip select is high
            if (!cs_n_s && strobe_s) // RULE12
            begin
               rd_next      = !rd_n_s;
               rdata_next   = hrd_pkg::RST_BYTE;
               mem_fwd_next = 1'b0;
               reg_fwd_next = 1'b0;
               ind_fwd_next = 1'b0;
               state_next   = hrd_pkg::ST_HOLD;
               if (mr_s) // RULE1
               begin
                  go           = 1'b1;
                  go_addr      = mem_addr;
                  go_wd        = {8'h00, data_s};
                  mem_fwd_next = 1'b1;
               end
               else if (pwr_save_en && cls.sync_type) // RULE8
               begin
                  // Synchronous side may be unclocked: never touch it
                  refused_next = 1'b1;
               end
               else if (cls.local_hit) // RULE4
               begin
                  if (addr_s[15:0] == hrd_pkg::OFF_IND_D1 && wr_n_s == 1'b0)
                  begin
                     go           = 1'b1;
                     go_addr      = iaddr_reg;
                     go16         = 1'b1;
                     go_wd        = {data_s, ilo_reg};
                     ind_fwd_next = 1'b1; // RULE6
                  end
                  else if (addr_s[15:0] == hrd_pkg::OFF_IND_D0 &&
                           rd_n_s == 1'b0)
                  begin
                     go           = 1'b1;
                     go_addr      = iaddr_reg;
                     go16         = 1'b1;
                     ind_fwd_next = 1'b1; // RULE6
                  end
                  else if (rd_n_s == 1'b0)
                  begin
                     unique case (addr_s[15:0])
                        hrd_pkg::OFF_UWA_LO:  rdata_next = uwa_reg[7:0];
                        hrd_pkg::OFF_UWA_HI:  rdata_next = uwa_reg[15:8];
                        hrd_pkg::OFF_UW_MASK: rdata_next = {3'h0, uwm_reg};
                        hrd_pkg::OFF_HCTL0:   rdata_next = hctl0_reg;
                        hrd_pkg::OFF_HCTL1:   rdata_next = hctl1_reg;
                        hrd_pkg::OFF_HCTL2:   rdata_next = hctl2_reg;
                        hrd_pkg::OFF_IND_CTL: rdata_next = ictl_reg;
                        hrd_pkg::OFF_IND_A0:  rdata_next = iaddr_reg[7:0];
                        hrd_pkg::OFF_IND_A1:  rdata_next = iaddr_reg[15:8];
                        hrd_pkg::OFF_IND_A2:  rdata_next = iaddr_reg[23:16];
                        hrd_pkg::OFF_IND_A3:  rdata_next = iaddr_reg[31:24];
                        hrd_pkg::OFF_IND_D1:  rdata_next = ihi_reg;
                        default:              rdata_next = hrd_pkg::RST_BYTE;
                     endcase
                  end
                  else
                  begin
                     unique case (addr_s[15:0])
                        hrd_pkg::OFF_UWA_LO:  uwa_next[7:0]    = data_s;
                        hrd_pkg::OFF_UWA_HI:  uwa_next[15:8]   = data_s;
                        hrd_pkg::OFF_UW_MASK: uwm_next         = data_s[4:0];
                        hrd_pkg::OFF_HCTL0:   hctl0_next       = data_s;
                        hrd_pkg::OFF_HCTL1:   hctl1_next       = data_s;
                        hrd_pkg::OFF_HCTL2:   hctl2_next       = data_s;
                        hrd_pkg::OFF_IND_CTL: ictl_next        = data_s;
                        hrd_pkg::OFF_IND_A0:  iaddr_next[7:0]  = data_s;
                        hrd_pkg::OFF_IND_A1:  iaddr_next[15:8] = data_s;
                        hrd_pkg::OFF_IND_A2:  iaddr_next[23:16] = data_s;
                        hrd_pkg::OFF_IND_A3:  iaddr_next[31:24] = data_s;
                        hrd_pkg::OFF_IND_D0:  ilo_next         = data_s;
                        default:              ilo_next         = ilo_reg;
                     endcase
                  end
               end
               else if (cls.shared) // RULE3 RULE7
               begin
                  go           = 1'b1;
                  go_addr      = hrd_pkg::INT_REG_BASE |
                                 {16'h0000, addr_s[15:0]};
                  go_wd        = {8'h00, data_s};
                  reg_fwd_next = 1'b1;
               end
            end
         end
         hrd_pkg::ST_BUSY:
         begin
            if (int_ack) // RULE11
            begin
               req_next   = 1'b0;
               state_next = hrd_pkg::ST_HOLD;
               if (rd_reg)
               begin
                  rdata_next = int_rdata[7:0];
                  if (ind_fwd_reg)
                  begin
                     ihi_next = int_rdata[15:8];
                  end
               end
            end
         end
         hrd_pkg::ST_HOLD:
         begin
            if (cs_n_s || !strobe_s)
            begin
               state_next = hrd_pkg::ST_IDLE;
            end
         end
      endcase
      if (go)
      begin
         // Converter ports and a disabled flash region are never reached
         if (blocked(go_addr, spi_flash_en)) // RULE9 RULE10
         begin
            refused_next = 1'b1;
         end
         else
         begin
            req_next   = 1'b1;
            we_next    = wr_n_s == 1'b0;
            sz16_next  = go16;
            iaout_next = go_addr;
            wd_next    = go_wd;
            state_next = hrd_pkg::ST_BUSY;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state_reg   <= hrd_pkg::ST_IDLE;
         uwa_reg     <= hrd_pkg::RST_HALF;
         uwm_reg     <= hrd_pkg::RST_MASK;
         hctl0_reg   <= hrd_pkg::RST_BYTE;
         hctl1_reg   <= hrd_pkg::RST_BYTE;
         hctl2_reg   <= hrd_pkg::RST_BYTE;
         ictl_reg    <= hrd_pkg::RST_BYTE;
         iaddr_reg   <= hrd_pkg::RST_WORD;
         ilo_reg     <= hrd_pkg::RST_BYTE;
         ihi_reg     <= hrd_pkg::RST_BYTE;
         rdata_reg   <= hrd_pkg::RST_BYTE;
         rd_reg      <= 1'b0;
         mem_fwd_reg <= 1'b0;
         reg_fwd_reg <= 1'b0;
         ind_fwd_reg <= 1'b0;
         refused_reg <= 1'b0;
         req_reg     <= 1'b0;
         we_reg      <= 1'b0;
         sz16_reg    <= 1'b0;
         iaout_reg   <= hrd_pkg::RST_WORD;
         wd_reg      <= hrd_pkg::RST_HALF;
      end
      else
      begin
         state_reg   <= state_next;
         uwa_reg     <= uwa_next;
         uwm_reg     <= uwm_next;
         hctl0_reg   <= hctl0_next;
         hctl1_reg   <= hctl1_next;
         hctl2_reg   <= hctl2_next;
         ictl_reg    <= ictl_next;
         iaddr_reg   <= iaddr_next;
         ilo_reg     <= ilo_next;
         ihi_reg     <= ihi_next;
         rdata_reg   <= rdata_next;
         rd_reg      <= rd_next;
         mem_fwd_reg <= mem_fwd_next;
         reg_fwd_reg <= reg_fwd_next;
         ind_fwd_reg <= ind_fwd_next;
         refused_reg <= refused_next;
         req_reg     <= req_next;
         we_reg      <= we_next;
         sz16_reg    <= sz16_next;
         iaout_reg   <= iaout_next;
         wd_reg      <= wd_next;
      end
   end

   assign int_req        = req_reg;
   assign int_we         = we_reg;
   assign int_size16     = sz16_reg;
   assign int_addr       = iaout_reg;
   assign int_wdata      = wd_reg;
   assign access_refused = refused_reg;
   assign host_data_out  = rdata_reg;
   assign host_ready     = state_reg == hrd_pkg::ST_HOLD;
   assign host_data_oe   = host_ready && rd_reg && !cs_n_s;

   AST_CS_IGNORE: assert property (@(posedge ref_clk) // RULE12
      disable iff (!reset_n)
      state_reg == hrd_pkg::ST_IDLE && cs_n_s |=>
      state_reg == hrd_pkg::ST_IDLE && !int_req && !access_refused)
      else $error("access decoded with chip select high");
   AST_MEM_LOW: assert property (@(posedge ref_clk) // RULE1
      disable iff (!reset_n)
      $rose(int_req) && mem_fwd_reg |-> int_addr[15:0] == addr_s[15:0])
      else $error("memory window low address wrong");
   AST_WIN_MASK: assert property (@(posedge ref_clk) // RULE5
      disable iff (!reset_n)
      $rose(int_req) && mem_fwd_reg |-> int_addr[31:16] ==
      {uwa_reg[15:5], (uwm_reg & addr_s[20:16]) | (~uwm_reg & uwa_reg[4:0])})
      else $error("upper window or mask not applied");
   AST_MIRROR: assert property (@(posedge ref_clk) // RULE7
      disable iff (!reset_n)
      $rose(int_req) && reg_fwd_reg |-> int_addr[31:16] ==
      hrd_pkg::INT_REG_BASE[31:16] && int_addr[15:0] == addr_s[15:0] &&
      !int_size16)
      else $error("shared register not mirrored");
   AST_INDIRECT: assert property (@(posedge ref_clk) // RULE6
      disable iff (!reset_n)
      $rose(int_req) && ind_fwd_reg |-> int_addr == iaddr_reg && int_size16)
      else $error("indirect access address or size wrong");
   AST_PSAVE: assert property (@(posedge ref_clk) // RULE8
      disable iff (!reset_n)
      state_reg == hrd_pkg::ST_IDLE && !cs_n_s && strobe_s && !mr_s &&
      pwr_save_en && cls.sync_type |=> access_refused ##1 !int_req)
      else $error("synchronous access in power save not refused");
   AST_NO_CONV: assert property (@(posedge ref_clk) // RULE9
      disable iff (!reset_n)
      int_req |-> !in_conv(int_addr))
      else $error("converter port reached from host");
   AST_REQ_HOLD: assert property (@(posedge ref_clk) // RULE11
      disable iff (!reset_n)
      int_req && !int_ack |=> int_req && $stable(int_addr) &&
      $stable(int_wdata))
      else $error("internal request dropped before answer");
   AST_ACK_DONE: assert property (@(posedge ref_clk) // RULE11
      disable iff (!reset_n)
      int_req && int_ack |=> !int_req && host_ready)
      else $error("answer not passed to host");
   AST_ASYNC_OK: assert property (@(posedge ref_clk) // RULE3
      disable iff (!reset_n)
      cls.offset inside {[16'h0020:16'h004f], [16'h0080:16'h0084]} |->
      !cls.sync_type)
      else $error("asynchronous offset classed synchronous");

endmodule // hrd_top

// ==== sim/hrd_int_bus_model.sv ====
// Internal bus slave standing behind the decoder's forwarding port
`timescale 1ns/1ps
module hrd_int_bus_model
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        int_req,
   input  wire logic [31:0] int_addr,
   output logic             int_ack,
   output logic      [15:0] int_rdata,
   input  wire logic [3:0]  ack_delay,
   output int               req_count
);
   int wait_cnt;

   always @(posedge ref_clk)
   begin
      int_ack   <= 1'b0;
      // Data is only valid with ack; otherwise it toggles every cycle
      int_rdata <= ~int_rdata;
      if (!reset_n)
      begin
         wait_cnt  <= 0;
         req_count <= 0;
         int_rdata <= 16'h0000;
      end
      else if (int_req && !int_ack)
      begin
         if (wait_cnt == 0)
            req_count <= req_count + 1;
         if (wait_cnt >= int'(ack_delay))
         begin
            int_ack   <= 1'b1;
            int_rdata <= int_addr[15:0] ^ 16'h5a3c;
            wait_cnt  <= 0;
         end
         else
            wait_cnt <= wait_cnt + 1;
      end
   end
endmodule // hrd_int_bus_model

// ==== sim/hrd_top_tb_top.sv ====
// Self-checking bench for the host register space decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   bad_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module hrd_top_tb_top;
   logic        ref_clk = 0, reset_n = 0, host_cs_n = 1, host_mr_sel = 0;
   logic        host_rd_n = 1, host_wr_n = 1, pwr_save_en = 0;
   logic        spi_flash_en = 1, host_data_oe, host_ready, int_req;
   logic        int_we, int_size16, int_ack, access_refused, cap_we, cap_sz;
   logic [20:0] host_address_lines = '0;
   logic [7:0]  host_data_in = '0, host_data_out, hreg [11];
   logic [31:0] int_addr, cap_addr;
   logic [15:0] int_wdata, int_rdata, cap_wd;
   logic [3:0]  ack_delay = '0;
   int          req_count, ref_cnt = 0, bad_count = 0;
   int          samples_checked = 0, seed = 95;
   logic [15:0] offs [11] = '{16'h80, 16'h81, 16'h82, 16'h84, 16'h85,
                              16'h8a, 16'ha6, 16'ha8, 16'ha9, 16'haa, 16'hab};

   always #12.5 ref_clk = ~ref_clk;

   hrd_top hrd_top_i (.ref_clk, .reset_n, .host_cs_n, .host_mr_sel,
      .host_rd_n, .host_wr_n, .host_address_lines, .host_data_in,
      .host_data_out, .host_data_oe, .host_ready, .pwr_save_en,
      .spi_flash_en, .int_req, .int_we, .int_size16, .int_addr, .int_wdata,
      .int_ack, .int_rdata, .access_refused);
   hrd_int_bus_model hrd_int_bus_model_i (.ref_clk, .reset_n, .int_req,
      .int_addr, .int_ack, .int_rdata, .ack_delay, .req_count);

   always @(posedge ref_clk)
   begin
      if (int_req && int_ack)
         {cap_addr, cap_wd, cap_we, cap_sz} <=
            {int_addr, int_wdata, int_we, int_size16};
      if (access_refused === 1'b1)
         ref_cnt <= ref_cnt + 1;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One host access; nf forwards and nr refusals are expected from it
   task automatic acc(input logic mr, input logic [20:0] a, input logic wr,
      input logic [7:0] d, input int nf, input int nr, output logic [7:0] rd);
      int n, q0, r0;
      q0 = req_count;
      r0 = ref_cnt;
      @(posedge ref_clk);
      {host_mr_sel, host_address_lines, host_data_in} <= {mr, a, d};
      {host_cs_n, host_wr_n, host_rd_n} <= {1'b0, !wr, wr};
      ack_delay <= 4'($random(seed) & 7);
      for (n = 0; n < 80 && host_ready !== 1'b1; n++) @(negedge ref_clk);
      if (n == 80)
      begin
         bad_count++;
         test_done();
      end
      rd = host_data_out;
      `CHK("data oe", !wr, host_data_oe)
      @(posedge ref_clk);
      {host_cs_n, host_wr_n, host_rd_n} <= 3'b111;
      for (n = 0; n < 40 && host_ready !== 1'b0; n++) @(negedge ref_clk);
      @(negedge ref_clk);
      if (n == 40)
      begin
         bad_count++;
         test_done();
      end
      `CHK("forwards", nf, req_count - q0)
      `CHK("refusals", nr, ref_cnt - r0)
   endtask

   initial
   begin
      logic [7:0] rd, d;
      logic [15:0] off;
      logic [31:0] ind, ea;
      logic [20:0] a;
      logic [4:0] m;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      foreach (offs[i])
      begin
         acc(0, {5'h0, offs[i]}, 0, 0, 0, 0, rd);
         `CHK("reset value", 8'h00, rd)
         d = 8'($random(seed));
         // Keep window and indirect targets out of the converter range
         if (i == 1 || i == 10) d[7] = 1'b0;
         hreg[i] = (i == 2) ? {3'h0, d[4:0]} : d;
         acc(0, {5'h0, offs[i]}, 1, d, 0, 0, rd);
      end
      foreach (offs[i])
      begin
         acc(0, {5'h15, offs[i]}, 0, 0, 0, 0, rd);
         `CHK("host reg", hreg[i], rd)
      end
      acc(0, 21'h83, 1, 8'hff, 0, 0, rd);
      acc(0, 21'h83, 0, 0, 0, 0, rd);
      `CHK("hole", 8'h00, rd)
      $display("host register test done");
      ind = {hreg[10], hreg[9], hreg[8], hreg[7]};
      d = 8'($random(seed));
      acc(0, 21'hac, 1, d, 0, 0, rd);
      acc(0, 21'had, 1, ~d, 1, 0, rd);
      `CHK("ind wr", {2'b11, ind, ~d, d},
         {cap_we, cap_sz, cap_addr, cap_wd})
      acc(0, 21'hac, 0, 0, 1, 0, rd);
      `CHK("ind rd", {2'b01, ind}, {cap_we, cap_sz, cap_addr})
      off = ind[15:0] ^ 16'h5a3c;
      `CHK("ind lo", off[7:0], rd)
      acc(0, 21'had, 0, 0, 0, 0, rd);
      `CHK("ind hi", off[15:8], rd)
      $display("indirect test done");
      for (int i = 0; i < 8; i++)
      begin
         off = 16'($random(seed)) >> (2 * i);
         if (off inside {[16'h0080:16'h00af]}) off[7] = 1'b0;
         a = {5'($random(seed)), off};
         d = 8'($random(seed));
         acc(0, a, 1, d, 1, 0, rd);
         `CHK("shared wr", {2'b10, 32'h3800_0000 | off, 8'h00, d},
            {cap_we, cap_sz, cap_addr, cap_wd})
         acc(0, a, 0, 0, 1, 0, rd);
         `CHK("shared rd", 8'(off ^ 16'h5a3c), rd)
      end
      $display("shared register test done");
      repeat (4)
      begin
         a = 21'($random(seed));
         m = hreg[2][4:0];
         ea = {hreg[1], hreg[0][7:5], (a[20:16] & m) | (hreg[0][4:0] & ~m),
               a[15:0]};
         d = 8'($random(seed));
         acc(1, a, 1, d, 1, 0, rd);
         `CHK("mem wr", {ea, 8'h00, d}, {cap_addr, cap_wd})
         acc(1, a, 0, 0, 1, 0, rd);
         `CHK("mem rd", 8'(ea[15:0] ^ 16'h5a3c), rd)
      end
      $display("memory window test done");
      acc(0, 21'h81, 1, 8'hf0, 0, 0, rd);
      acc(1, 21'h0, 0, 0, 0, 1, rd);
      `CHK("converter rd", 8'h00, rd)
      acc(0, 21'h81, 1, 8'h20, 0, 0, rd);
      @(posedge ref_clk) spi_flash_en <= 1'b0;
      acc(1, 21'h0, 0, 0, 0, 1, rd);
      `CHK("flash rd", 8'h00, rd)
      @(posedge ref_clk) spi_flash_en <= 1'b1;
      acc(1, 21'h0, 0, 0, 1, 0, rd);
      @(posedge ref_clk) pwr_save_en <= 1'b1;
      acc(0, 21'h10, 0, 0, 0, 1, rd);
      `CHK("save sync rd", 8'h00, rd)
      acc(0, 21'ha8, 1, 8'h55, 0, 1, rd);
      acc(0, 21'h30, 1, 8'h11, 1, 0, rd);
      acc(0, 21'h80, 0, 0, 0, 0, rd);
      `CHK("save async rd", hreg[0], rd)
      @(posedge ref_clk) pwr_save_en <= 1'b0;
      acc(0, 21'ha8, 0, 0, 0, 0, rd);
      `CHK("refused wr", hreg[7], rd)
      $display("refusal test done");
      @(posedge ref_clk);
      {host_mr_sel, host_address_lines, host_data_in} <= {1'b0, 21'h80, 8'hee};
      host_wr_n <= 1'b0;
      repeat (12) @(negedge ref_clk)
         `CHK("cs high", 1'b0, host_ready | int_req)
      @(posedge ref_clk) host_wr_n <= 1'b1;
      acc(0, 21'h80, 0, 0, 0, 0, rd);
      `CHK("cs high wr", hreg[0], rd)
      $display("chip select test done");
      test_done();
   end
endmodule // hrd_top_tb_top
